/* File: shared/flash_front_pkg.sv */
// Constants, opcodes, widths and state types of the serial flash bus front end.
// Assumes a single 20 MHz core clock that oversamples every bus pin.
package flash_front_pkg;

   // ---------------------------------------------------------------
   // Clocking
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50; // Core clock period in ns.
   localparam int SYNC_STAGES = 2; // Flip-flops in front of any pin logic.

   // ---------------------------------------------------------------
   // Instruction codes
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_READ = 8'h03; // Plain single-line read.
   localparam logic [7:0] OP_FAST_READ = 8'h0b; // Single-line fast read.
   localparam logic [7:0] OP_DUAL_OUT = 8'h3b; // Dual output read.
   localparam logic [7:0] OP_DUAL_IO = 8'hbb; // Dual address and data read.
   localparam logic [7:0] OP_QUAD_OUT = 8'h6b; // Quad output read.
   localparam logic [7:0] OP_QUAD_IO = 8'heb; // Quad address and data read.
   localparam logic [7:0] OP_QUAD_WORD = 8'he7; // Quad word read.
   localparam logic [7:0] OP_QUAD_OCTAL = 8'he3; // Quad octal word read.
   localparam logic [7:0] OP_ENTER_FOUR_PIN = 8'h38; // Enter four-pin instructions.
   localparam logic [7:0] OP_EXIT_FOUR_PIN = 8'hff; // Leave four-pin instructions.
   localparam logic [7:0] OP_SOFT_RESET = 8'h99; // Software reset.

   // ---------------------------------------------------------------
   // Byte framing and address layout
   // ---------------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE = 4'h8; // Bits in one transferred byte.
   localparam logic [1:0] ADDR_BYTES = 2'h3; // Address bytes after a read opcode.
   localparam int ADDR_WIDTH = 21; // Bytes 000000h to 1FFFFFh.
   localparam int PAGE_LSB = 8; // 256-byte pages.
   localparam int SECTOR_LSB = 12; // 4 KB sectors of 16 pages.
   localparam int HALF_BLOCK_LSB = 15; // 32 KB blocks of 128 pages.
   localparam int BLOCK_LSB = 16; // 64 KB blocks of 256 pages.
   localparam int PAGE_WIDTH = ADDR_WIDTH - PAGE_LSB; // 8192 pages.
   localparam int SECTOR_WIDTH = ADDR_WIDTH - SECTOR_LSB; // 512 sectors.
   localparam int HALF_BLOCK_WIDTH = ADDR_WIDTH - HALF_BLOCK_LSB; // 64 half-blocks.
   localparam int BLOCK_WIDTH = ADDR_WIDTH - BLOCK_LSB; // 32 blocks.

   // ---------------------------------------------------------------
   // Reset values and fill byte
   // ---------------------------------------------------------------
   localparam logic [7:0] IDLE_FILL_BYTE = 8'hff; // Shifted out on underrun.
   localparam logic [1:0] PROTECT_HW_MODE = 2'h1; // Protect bits for pin control.
   localparam logic FOUR_PIN_RESET = 1'b0; // Serial instruction mode at reset.

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {LANE1, LANE2, LANE4} lanes_type; // Data lines used.
   typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DATA_IN, PH_DATA_OUT} phase_type;

endpackage : flash_front_pkg

/* File: logic/flash_front.sv */
// Serial bus front end of a 2 MB NOR flash: opcode, address and data capture,
// read-data shifting on one, two or four lines, pause handling and address decode.
// Assumes the bus pins arrive asynchronously and the serial clock is far slower
// than i_clk; the array engine sits behind the receive and transmit streams.
`timescale 1ns/10ps
module flash_front
   import flash_front_pkg::*;
(
   input wire logic i_clk, // Core clock, 20 MHz.
   input wire logic i_arst_n, // Asynchronous reset, active low.
   input wire logic i_sclk, // Serial clock from the host.
   input wire logic i_cs_n, // Chip select, active low.
   input wire logic i_data_line0, // Data line 0, also serial_in_pin.
   input wire logic i_data_line1, // Data line 1, serial output in single mode.
   input wire logic i_data_line2, // Data line 2, or write-protect pin (low active).
   input wire logic i_data_line3, // Data line 3, or pause pin (low active).
   output logic o_data_line0, // Driven level of data line 0.
   output logic o_data_line1, // Driven level of data line 1.
   output logic o_data_line2, // Driven level of data line 2.
   output logic o_data_line3, // Driven level of data line 3.
   output logic o_data_line0_oe_n, // Low while line 0 is driven.
   output logic o_data_line1_oe_n, // Low while line 1 is driven.
   output logic o_data_line2_oe_n, // Low while line 2 is driven.
   output logic o_data_line3_oe_n, // Low while line 3 is driven.
   input wire logic i_quad_enable_bit, // Non-volatile quad enable.
   input wire logic [1:0] i_status_protect_bits, // Status protection selection.
   output logic o_status_write_allowed, // Status writes currently permitted.
   output logic o_four_pin_instruction_mode, // Four-pin instruction mode active.
   output logic o_selected, // Chip selected and armed.
   output logic o_paused, // Pause in force.
   output logic o_rx_valid, // Received byte waiting.
   output logic [7:0] o_rx_data, // Received byte.
   output logic o_rx_is_opcode, // Received byte is an opcode.
   input wire logic i_rx_ready, // Consumer takes the received byte.
   output logic o_rx_overflow, // Sticky: a byte arrived while the buffer was full.
   input wire logic i_tx_valid, // Read byte offered.
   input wire logic [7:0] i_tx_data, // Read byte.
   output logic o_tx_ready, // One-cycle pulse: read byte taken.
   output logic o_addr_valid, // One-cycle pulse: address decoded.
   output logic [PAGE_WIDTH-1:0] o_page, // Page index.
   output logic [SECTOR_WIDTH-1:0] o_sector, // Sector index.
   output logic [HALF_BLOCK_WIDTH-1:0] o_half_block, // 32 KB block index.
   output logic [BLOCK_WIDTH-1:0] o_block, // 64 KB block index.
   output logic o_cmd_rejected // One-cycle pulse: quad opcode without quad enable.
);

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------

   // Number of bits one serial clock moves on the given lanes.
   function automatic logic [3:0] lane_bits(input lanes_type lanes);
      case (lanes)
         LANE2: lane_bits = 4'h2;
         LANE4: lane_bits = 4'h4;
         default: lane_bits = 4'h1;
      endcase
   endfunction : lane_bits

   // Shifts the sampled lines into a byte, most significant bits first.
   function automatic logic [7:0] shift_in(input logic [7:0] cur, input lanes_type lanes,
                                           input logic [3:0] dq);
      case (lanes)
         LANE2: shift_in = {cur[5:0], dq[1:0]};
         LANE4: shift_in = {cur[3:0], dq};
         default: shift_in = {cur[6:0], dq[0]};
      endcase
   endfunction : shift_in

   // True for the quad read opcodes.
   function automatic logic is_quad_read(input logic [7:0] op);
      is_quad_read = (op == OP_QUAD_OUT) || (op == OP_QUAD_IO) ||
                     (op == OP_QUAD_WORD) || (op == OP_QUAD_OCTAL);
   endfunction : is_quad_read

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [SYNC_STAGES-1:0] sclk_sync_q; // Serial clock synchroniser.
   logic [SYNC_STAGES-1:0] cs_sync_q; // Chip select synchroniser.
   logic [SYNC_STAGES-1:0] dq_sync_q [4]; // Data line synchronisers.
   logic sclk_last_q; // Previous synchronised serial clock.
   logic cs_last_q; // Previous synchronised chip select.

   // Every pin passes two flip-flops; only the second stage is read by logic.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         sclk_sync_q <= '0;
         cs_sync_q <= '1;
         sclk_last_q <= 1'b0;
         cs_last_q <= 1'b1;
         for (int i = 0; i < 4; i++) dq_sync_q[i] <= '1;
      end
      else
      begin
         sclk_sync_q <= {sclk_sync_q[0], i_sclk};
         cs_sync_q <= {cs_sync_q[0], i_cs_n};
         sclk_last_q <= sclk_sync_q[1];
         cs_last_q <= cs_sync_q[1];
         dq_sync_q[0] <= {dq_sync_q[0][0], i_data_line0};
         dq_sync_q[1] <= {dq_sync_q[1][0], i_data_line1};
         dq_sync_q[2] <= {dq_sync_q[2][0], i_data_line2};
         dq_sync_q[3] <= {dq_sync_q[3][0], i_data_line3};
      end
   end

   // ---------------------------------------------------------------
   // Decoded pin events
   // ---------------------------------------------------------------
   wire sclk_level = sclk_sync_q[1];
   wire sclk_rise = sclk_level && !sclk_last_q;
   wire sclk_fall = !sclk_level && sclk_last_q;
   wire cs_low = !cs_sync_q[1];
   wire cs_fall = cs_low && cs_last_q;
   wire cs_rise = !cs_low && !cs_last_q;
   wire [3:0] dq_in = {dq_sync_q[3][1], dq_sync_q[2][1], dq_sync_q[1][1], dq_sync_q[0][1]};

   // ---------------------------------------------------------------
   // State registers
   // ---------------------------------------------------------------
   logic armed_q; // Select has fallen since reset.
   logic four_pin_q, four_pin_d; // Four-pin instruction mode.
   logic paused_q, paused_d; // Pause in force.
   phase_type phase_q, phase_d; // Transfer phase.
   lanes_type addr_lanes_q, addr_lanes_d; // Lanes for the address.
   lanes_type data_lanes_q, data_lanes_d; // Lanes for data.
   logic [7:0] shift_q, shift_d; // Receive shift register.
   logic [3:0] bit_cnt_q, bit_cnt_d; // Bits received in this byte.
   logic [1:0] addr_cnt_q, addr_cnt_d; // Address bytes received.
   logic [23:0] addr_q, addr_d; // Address being assembled.
   logic [7:0] out_q, out_d; // Transmit shift register.
   logic [3:0] out_cnt_q, out_cnt_d; // Bits left in the transmit byte.
   logic [3:0] dq_out_d; // Next driven line levels.
   logic [3:0] dq_oe_n_d; // Next line enables.

   // Edges are found only while selected, so the idle clock level between
   // frames never counts, whichever of the two modes the host uses.
   wire active = cs_low && armed_q && !paused_q;
   wire take_rise = active && sclk_rise;
   wire take_fall = active && sclk_fall;

   // Current receive width: four lines for opcodes in four-pin mode.
   wire lanes_type rx_lanes = (phase_q == PH_OPCODE) ? (four_pin_q ? LANE4 : LANE1) :
                              (phase_q == PH_ADDR) ? addr_lanes_q : data_lanes_q;
   wire [7:0] rx_shift = shift_in(shift_q, rx_lanes, dq_in);
   wire [3:0] rx_cnt = bit_cnt_q + lane_bits(rx_lanes);
   wire byte_done = take_rise && (rx_cnt == BITS_PER_BYTE);

   // Opcode classification.
   wire op_quad = is_quad_read(rx_shift);
   wire op_dual = (rx_shift == OP_DUAL_OUT) || (rx_shift == OP_DUAL_IO);
   wire op_read = op_quad || op_dual || (rx_shift == OP_READ) || (rx_shift == OP_FAST_READ);
   wire quad_refused = op_quad && !i_quad_enable_bit;

   // Pause pin is live only outside quad use of line 3.
   wire pause_usable = !i_quad_enable_bit && !four_pin_q && (data_lanes_q != LANE4);
   wire pause_req = pause_usable && cs_low && !dq_in[3];

   // Protect pin is live only while line 2 is not a data line.
   wire protect_pin_low = !i_quad_enable_bit && !dq_in[2];

   // ---------------------------------------------------------------
   // Receive and control next state
   // ---------------------------------------------------------------
   always_comb
   begin
      four_pin_d = four_pin_q;
      phase_d = phase_q;
      addr_lanes_d = addr_lanes_q;
      data_lanes_d = data_lanes_q;
      shift_d = shift_q;
      bit_cnt_d = bit_cnt_q;
      addr_cnt_d = addr_cnt_q;
      addr_d = addr_q;
      if (take_rise)
      begin
         shift_d = rx_shift;
         bit_cnt_d = byte_done ? 4'h0 : rx_cnt;
      end
      if (byte_done)
      begin
         case (phase_q)
            PH_OPCODE:
            begin
               // Width of the following phases comes from the opcode, or is four lines in four-pin mode.
               if (four_pin_q)
               begin
                  addr_lanes_d = LANE4;
                  data_lanes_d = LANE4;
               end
               else if (op_quad)
               begin
                  addr_lanes_d = (rx_shift == OP_QUAD_OUT) ? LANE1 : LANE4;
                  data_lanes_d = LANE4;
               end
               else if (op_dual)
               begin
                  addr_lanes_d = (rx_shift == OP_DUAL_IO) ? LANE2 : LANE1;
                  data_lanes_d = LANE2;
               end
               else
               begin
                  addr_lanes_d = LANE1;
                  data_lanes_d = LANE1;
               end
               addr_cnt_d = 2'h0;
               phase_d = (op_read && !quad_refused) ? PH_ADDR : PH_DATA_IN;
               if ((rx_shift == OP_ENTER_FOUR_PIN) && i_quad_enable_bit)
                  four_pin_d = 1'b1;
               else if ((rx_shift == OP_EXIT_FOUR_PIN) || (rx_shift == OP_SOFT_RESET))
                  four_pin_d = 1'b0;
            end
            PH_ADDR:
            begin
               addr_d = {addr_q[15:0], rx_shift};
               addr_cnt_d = addr_cnt_q + 2'h1;
               if (addr_cnt_q == ADDR_BYTES - 2'h1)
                  phase_d = PH_DATA_OUT;
            end
            default:
            begin
               // Data-in bytes only go to the receive stream.
               phase_d = phase_q;
            end
         endcase
      end
      if (cs_rise)
      begin
         // Partial instruction abandoned on deselect.
         phase_d = PH_OPCODE;
         bit_cnt_d = 4'h0;
         data_lanes_d = LANE1;
      end
   end

   // ---------------------------------------------------------------
   // Pause next state
   // ---------------------------------------------------------------
   // A change of the pause pin applies at once while the clock is low; with
   // the clock high it waits until the clock has fallen.
   always_comb
   begin
      paused_d = paused_q;
      if (!pause_usable || !cs_low)
         paused_d = 1'b0;
      else if (!sclk_level)
         paused_d = pause_req;
   end

   // ---------------------------------------------------------------
   // Transmit next state
   // ---------------------------------------------------------------
   wire need_byte = take_fall && (phase_q == PH_DATA_OUT) && (out_cnt_q == 4'h0);
   wire [7:0] tx_byte = i_tx_valid ? i_tx_data : IDLE_FILL_BYTE;
   wire [7:0] tx_cur = need_byte ? tx_byte : out_q;
   wire [3:0] tx_step = lane_bits(data_lanes_q);
   wire driving = active && (phase_q == PH_DATA_OUT);

   // Shifts out the top bits of the current byte on each falling edge.
   always_comb
   begin
      out_d = out_q;
      out_cnt_d = out_cnt_q;
      dq_out_d = {o_data_line3, o_data_line2, o_data_line1, o_data_line0};
      if (take_fall && (phase_q == PH_DATA_OUT))
      begin
         case (data_lanes_q)
            LANE4: dq_out_d = tx_cur[7:4];
            LANE2: dq_out_d = {2'b11, tx_cur[7:6]};
            default: dq_out_d = {2'b11, tx_cur[7], 1'b1};
         endcase
         out_d = tx_cur << tx_step;
         out_cnt_d = (need_byte ? BITS_PER_BYTE : out_cnt_q) - tx_step;
      end
      if (cs_rise)
         out_cnt_d = 4'h0;
      case (data_lanes_q)
         LANE4: dq_oe_n_d = driving ? 4'b0000 : 4'b1111;
         LANE2: dq_oe_n_d = driving ? 4'b1100 : 4'b1111;
         default: dq_oe_n_d = driving ? 4'b1101 : 4'b1111;
      endcase
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         armed_q <= 1'b0;
         four_pin_q <= FOUR_PIN_RESET;
         paused_q <= 1'b0;
         phase_q <= PH_OPCODE;
         addr_lanes_q <= LANE1;
         data_lanes_q <= LANE1;
         shift_q <= 8'h00;
         bit_cnt_q <= 4'h0;
         addr_cnt_q <= 2'h0;
         addr_q <= 24'h000000;
      end
      else
      begin
         armed_q <= armed_q || cs_fall;
         four_pin_q <= four_pin_d;
         paused_q <= paused_d;
         phase_q <= phase_d;
         addr_lanes_q <= addr_lanes_d;
         data_lanes_q <= data_lanes_d;
         shift_q <= shift_d;
         bit_cnt_q <= bit_cnt_d;
         addr_cnt_q <= addr_cnt_d;
         addr_q <= addr_d;
      end
   end

   // ---------------------------------------------------------------
   // Transmit registers and pin drivers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         out_q <= 8'h00;
         out_cnt_q <= 4'h0;
         {o_data_line3, o_data_line2, o_data_line1, o_data_line0} <= 4'hf;
         {o_data_line3_oe_n, o_data_line2_oe_n, o_data_line1_oe_n, o_data_line0_oe_n} <= 4'hf;
         o_tx_ready <= 1'b0;
      end
      else
      begin
         out_q <= out_d;
         out_cnt_q <= out_cnt_d;
         {o_data_line3, o_data_line2, o_data_line1, o_data_line0} <= dq_out_d;
         {o_data_line3_oe_n, o_data_line2_oe_n, o_data_line1_oe_n, o_data_line0_oe_n} <= dq_oe_n_d;
         o_tx_ready <= need_byte && i_tx_valid;
      end
   end

   // ---------------------------------------------------------------
   // Two-entry receive buffer
   // ---------------------------------------------------------------
   // Entry 0 is the output register; entry 1 catches a byte while the consumer
   // stalls, so one stall of a byte time loses nothing.
   logic spare_valid_q; // Entry 1 holds a byte.
   logic [8:0] spare_q; // Entry 1 contents, opcode flag on top.
   wire push = byte_done;
   wire [8:0] push_word = {phase_q == PH_OPCODE, rx_shift};
   wire pop = o_rx_valid && i_rx_ready;
   wire head_free = !o_rx_valid || pop;

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_rx_valid <= 1'b0;
         o_rx_data <= 8'h00;
         o_rx_is_opcode <= 1'b0;
         spare_valid_q <= 1'b0;
         spare_q <= 9'h000;
         o_rx_overflow <= 1'b0;
      end
      else
      begin
         if (head_free)
         begin
            // Head refills from the spare entry first, keeping byte order.
            o_rx_valid <= spare_valid_q || push;
            {o_rx_is_opcode, o_rx_data} <= spare_valid_q ? spare_q : push_word;
            spare_valid_q <= spare_valid_q && push;
            if (spare_valid_q && push)
               spare_q <= push_word;
         end
         else if (push && !spare_valid_q)
         begin
            spare_valid_q <= 1'b1;
            spare_q <= push_word;
         end
         o_rx_overflow <= o_rx_overflow || (push && !head_free && spare_valid_q);
      end
   end

   // ---------------------------------------------------------------
   // Status outputs and address decode
   // ---------------------------------------------------------------
   // Sector n starts at n times 4 KB; blocks nest sectors and pages.
   wire [ADDR_WIDTH-1:0] dec_addr = addr_d[ADDR_WIDTH-1:0];
   wire addr_done = byte_done && (phase_q == PH_ADDR) && (addr_cnt_q == ADDR_BYTES - 2'h1);

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_status_write_allowed <= 1'b1;
         o_four_pin_instruction_mode <= FOUR_PIN_RESET;
         o_selected <= 1'b0;
         o_paused <= 1'b0;
         o_addr_valid <= 1'b0;
         o_page <= '0;
         o_sector <= '0;
         o_half_block <= '0;
         o_block <= '0;
         o_cmd_rejected <= 1'b0;
      end
      else
      begin
         o_status_write_allowed <= !((i_status_protect_bits == PROTECT_HW_MODE)
                                     && protect_pin_low);
         o_four_pin_instruction_mode <= four_pin_d;
         o_selected <= cs_low && (armed_q || cs_fall);
         o_paused <= paused_d;
         o_addr_valid <= addr_done;
         if (addr_done)
         begin
            o_page <= dec_addr[ADDR_WIDTH-1:PAGE_LSB];
            o_sector <= dec_addr[ADDR_WIDTH-1:SECTOR_LSB];
            o_half_block <= dec_addr[ADDR_WIDTH-1:HALF_BLOCK_LSB];
            o_block <= dec_addr[ADDR_WIDTH-1:BLOCK_LSB];
         end
         o_cmd_rejected <= byte_done && (phase_q == PH_OPCODE) && quad_refused;
      end
   end

endmodule : flash_front

/* File: sim/flash_front_monitor.sv */
// Port checker of the flash front end.
// Assumes one core clock and the async reset.
`timescale 1ns/10ps
module flash_front_monitor
(
   input wire logic i_clk, i_arst_n, i_cs_n, i_data_line2, i_quad_enable_bit,
   input wire logic [1:0] i_status_protect_bits,
   input wire logic o_data_line1_oe_n, o_selected, o_paused, o_cmd_rejected,
   input wire logic o_four_pin_instruction_mode, o_status_write_allowed, o_tx_ready
);
   default clocking c @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // Long deselect and a held hardware lock.
   sequence s_idle; i_cs_n [*6]; endsequence
   sequence s_lock;
      (i_status_protect_bits == 2'h1 && !i_data_line2 && !i_quad_enable_bit) [*4];
   endsequence
   a_idle_float: assert property (s_idle |-> o_data_line1_oe_n)
      else $error("line driven while idle");
   a_idle_unarmed: assert property (s_idle |-> !o_selected)
      else $error("selected while idle");
   a_mode_needs_qe: assert property ($rose(o_four_pin_instruction_mode) |-> i_quad_enable_bit)
      else $error("mode without quad enable");
   a_hw_lock: assert property (s_lock |=> !o_status_write_allowed)
      else $error("status write open");
   a_pin_released: assert property (i_quad_enable_bit [*4] |=> o_status_write_allowed)
      else $error("status write shut");
   a_reject_cause: assert property (o_cmd_rejected |-> !i_quad_enable_bit)
      else $error("bad reject");
   a_pause_float: assert property (o_paused [*2] |-> o_data_line1_oe_n)
      else $error("driven in pause");
   a_pause_quad: assert property (i_quad_enable_bit |=> !o_paused)
      else $error("pause while quad enable set");
   a_tx_spacing: assert property (o_tx_ready |=> !o_tx_ready [*8])
      else $error("bytes too close");
endmodule : flash_front_monitor
bind flash_front flash_front_monitor mon (.*);

/* File: sim/spi_host_model.sv */
// Host model: bus master in mode 0, or in mode 3 while m3 is set.
// Assumes pull-ups on all data lines.
`timescale 1ns/10ps
module spi_host_model
(
   output logic i_sclk, i_cs_n,
   output logic i_data_line0, i_data_line1, i_data_line2, i_data_line3,
   input wire logic o_data_line0, o_data_line1, o_data_line2, o_data_line3,
   input wire logic o_data_line0_oe_n, o_data_line1_oe_n, o_data_line2_oe_n, o_data_line3_oe_n
);
   logic [3:0] hd = 4'hf, he = 4'h0, l;
   bit m3 = 0; // Idle clock level: 0 for mode 0, 1 for mode 3.
   wire [3:0] dv = {o_data_line3, o_data_line2, o_data_line1, o_data_line0};
   wire [3:0] dn = {o_data_line3_oe_n, o_data_line2_oe_n, o_data_line1_oe_n, o_data_line0_oe_n};
   // Device wins, then host, then the pull-up.
   assign {i_data_line3, i_data_line2, i_data_line1, i_data_line0} = ~dn & dv | dn & (he & hd | ~he);
   initial {i_sclk, i_cs_n} = 2'b01;
   task automatic start(); i_sclk = m3; #200 i_cs_n = 0; #200; endtask : start
   task automatic stop(); i_sclk = m3; #200 i_cs_n = 1; he = 4'h0; #400; endtask : stop
   // One byte over w lines, top bits first; rd listens instead.
   // Each bit opens with a fall; the clock is left high for stop to park.
   task automatic xfer(input logic [7:0] b, input int w, input bit rd, output logic [7:0] r);
      r = 8'h00;
      for (int i = 8 - w; i >= 0; i -= w)
      begin
         he = rd ? 4'h0 : 4'hf >> (4 - w);
         hd = 4'(b >> i);
         i_sclk = 0;
         #200 i_sclk = 1;
         #199 l = {i_data_line3, i_data_line2, i_data_line1, i_data_line0};
         r = (r << w) | ((w == 1) ? 8'(l[1]) : 8'(l & (4'hf >> (4 - w))));
         #1;
      end
   endtask : xfer
endmodule : spi_host_model

/* File: sim/tb_top.sv */
// Bench of the flash front end.
// Assumes package and host model.
`timescale 1ns/10ps
module tb_top
   import flash_front_pkg::*;
;
   logic i_clk = 0, i_arst_n = 0, i_quad_enable_bit = 0, i_rx_ready = 1, i_tx_valid = 1, rej = 0;
   logic [1:0] i_status_protect_bits = 2'h0;
   logic [1:0] pul = 2'h0; // Latched pulses: byte taken, address decoded.
   logic [7:0] i_tx_data = 8'h96, r, op, adr [3] = '{8'h01, 8'h23, 8'h45};
   logic [7:0] ex [2] = '{OP_EXIT_FOUR_PIN, OP_SOFT_RESET};
   wire i_sclk, i_cs_n, i_data_line0, i_data_line1, i_data_line2, i_data_line3;
   wire o_data_line0, o_data_line1, o_data_line2, o_data_line3, o_selected, o_paused;
   wire o_data_line0_oe_n, o_data_line1_oe_n, o_data_line2_oe_n, o_data_line3_oe_n;
   wire o_status_write_allowed, o_four_pin_instruction_mode, o_rx_valid, o_rx_is_opcode;
   wire o_rx_overflow, o_tx_ready, o_addr_valid, o_cmd_rejected;
   wire [7:0] o_rx_data;
   wire [PAGE_WIDTH-1:0] o_page;
   wire [SECTOR_WIDTH-1:0] o_sector;
   wire [HALF_BLOCK_WIDTH-1:0] o_half_block;
   wire [BLOCK_WIDTH-1:0] o_block;
   int miscompares = 0, compares = 0, cyc = 0;
   flash_front uut (.*);
   spi_host_model h (.*);
   always #25 i_clk = ~i_clk;
   task automatic wrap_up();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   task automatic check(input string n, input logic [15:0] s, e);
      compares++;
      if (s !== e)
      begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask : check
   // Opcode, address and one read byte.
   task automatic rd(input logic [7:0] c, input int w);
      h.start();
      h.xfer(c, 1, 0, r);
      foreach (adr[i]) h.xfer(adr[i], 1, 0, r);
      h.xfer(8'h00, w, 1, r);
      h.stop();
   endtask : rd
   task automatic one(input logic [7:0] c, input int w);
      h.start();
      h.xfer(c, w, 0, r);
      h.stop();
      @(negedge i_clk);
   endtask : one
   // Opcode capture, reject latch and the hang limit.
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (o_rx_valid && i_rx_ready && o_rx_is_opcode)
         op <= o_rx_data;
      if (o_cmd_rejected)
         rej <= 1;
      pul <= pul | {o_tx_ready, o_addr_valid};
      if (cyc == 20000)
      begin
         miscompares++;
         wrap_up();
      end
   end
   initial
   begin
      repeat (3) @(negedge i_clk);
      i_arst_n = 1;
      check("mode", o_four_pin_instruction_mode, 0);
      rd(OP_READ, 1);
      check("data", r, 8'h96);
      check("op", op, OP_READ);
      check("page", o_page, 16'h0123);
      check("sector", o_sector, 16'h012);
      check("half", o_half_block, 16'h2);
      check("block", o_block, 16'h1);
      check("pulses", pul, 2'h3);
      rd(OP_DUAL_OUT, 2);
      check("dual", r, 8'h96);
      rd(OP_QUAD_OUT, 4);
      check("reject", rej, 1);
      one(OP_ENTER_FOUR_PIN, 1);
      check("mode", o_four_pin_instruction_mode, 0);
      h.start();
      h.hd = 4'h0;
      h.he = 4'h8;
      repeat (8) @(negedge i_clk);
      check("pause", {o_paused, o_data_line1_oe_n}, 2'h3);
      h.he = 4'h4;
      repeat (8) @(negedge i_clk);
      check("resume", o_paused, 0);
      h.stop();
      @(negedge i_clk);
      i_status_protect_bits = 2'h1;
      h.he = 4'h4;
      repeat (8) @(negedge i_clk);
      check("locked", o_status_write_allowed, 0);
      i_quad_enable_bit = 1;
      repeat (8) @(negedge i_clk);
      check("unlocked", o_status_write_allowed, 1);
      rd(OP_QUAD_OUT, 4);
      check("quad", r, 8'h96);
      foreach (ex[i])
      begin
         one(OP_ENTER_FOUR_PIN, 1);
         check("enter", o_four_pin_instruction_mode, 1);
         one(ex[i], 4);
         check("leave", o_four_pin_instruction_mode, 0);
      end
      h.m3 = 1;
      i_rx_ready = 0;
      rd(OP_READ, 1);
      check("full", {o_rx_overflow, o_rx_data}, {1'b1, OP_READ});
      check("mode3", r, 8'h96);
      @(negedge i_clk);
      i_rx_ready = 1;
      repeat (4) @(negedge i_clk);
      check("drain", o_rx_valid, 0);
      wrap_up();
   end
endmodule : tb_top
